/* File: bench/spd_core_bench.sv */
// Self-checking bench for the packed-vector datapath.
`timescale 1ns/1ps
module spd_core_bench;
  import spd_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, in_valid = 1'b0, stream_flush = 1'b0;
  spd_cmd_s cmd = '0;
  logic [127:0] dst = '0, src = '0;
  logic [127:0] mask = {8{16'h8000}};
  logic [7:0] imm = '0;
  logic [7:0] lat = 8'h06;
  logic [63:0] gpr_in = 64'hab, addr = '0;
  logic [1:0] round_ctl = 2'h1;
  logic fill_valid, out_valid, zero_flag, carry_flag, busy, mem_req;
  logic [SPD_LINE_BITS-1:0] fill_line;
  logic [127:0] result;
  logic [63:0] gpr_out;
  logic [SPD_LINE_TAG_BITS-1:0] mem_line_addr;
  int error_cnt = 0, total_checks = 0;
  always #12.5 clk = ~clk;
  spd_core dut(.clk(clk), .sys_rst(sys_rst), .in_valid(in_valid), .cmd(cmd), .dst(dst),
    .src(src), .mask(mask), .imm(imm), .gpr_in(gpr_in), .addr(addr), .round_ctl(round_ctl),
    .stream_flush(stream_flush), .fill_valid(fill_valid), .fill_line(fill_line),
    .out_valid(out_valid), .result(result), .gpr_out(gpr_out), .zero_flag(zero_flag),
    .carry_flag(carry_flag), .busy(busy), .mem_req(mem_req), .mem_line_addr(mem_line_addr));
  spd_mem_model mem(.clk(clk), .sys_rst(sys_rst), .mem_req(mem_req), .line_addr(mem_line_addr),
    .lat(lat), .fill_valid(fill_valid), .fill_line(fill_line));
  task automatic summarize;
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string n, logic [127:0] e, logic [127:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic issue(spd_op_e op, logic [5:0] f, logic [7:0] i, logic [127:0] d, s);
    @(posedge clk);
    #1;
    in_valid = 1'b1;
    cmd = {op, f};
    imm = i;
    dst = d;
    src = s;
    @(posedge clk);
    #1;
    in_valid = 1'b0;
  endtask
  task automatic run(string n, spd_op_e op, logic [5:0] f, logic [7:0] i, logic [127:0] d, s, e);
    issue(op, f, i, d, s);
    chk({n, " valid"}, 128'h1, 128'(out_valid));
    chk(n, e, result);
  endtask
  task automatic wait_out;
    for (int k = 0; k < 50 && out_valid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic sc_int;
    logic [127:0] d = 128'h1f1e1d1c1b1a19181716151413121110;
    logic [127:0] s = 128'h0f0e0d0c0b0a09080706050403020100;
    run("sign", SPD_APPLY_SIGN, 6'h10, 8'h0, {8{16'h5}}, {2{64'h0001800000007fff}},
      {2{64'h0005fffb00000005}});
    for (int i = 5; i < 40; i += 15) begin
      run("align", SPD_BYTE_ALIGN_CONCAT, 6'h0, 8'(i), d, s, 128'({d, s} >> (8 * i)));
    end
    run("al64", SPD_BYTE_ALIGN_CONCAT, 6'h2, 8'h3, d, s, {64'h0, 64'({d[63:0], s[63:0]} >> 24)});
    run("lmul", SPD_LOW_DWORD_MULTIPLY, 6'h0, 8'h0, {4{32'h10001}}, {4{32'h10001}},
      {4{32'h20001}});
    run("wmul", SPD_WIDENING_MULTIPLY, 6'h0, 8'h0, {2{64'hfffffffe}}, {2{64'h3}},
      {2{64'hfffffffffffffffa}});
  endtask
  task automatic sc_fp;
    run("dot", SPD_DOT_PRODUCT, 6'h0, 8'h3f, {4{32'h3f800000}}, {4{32'h40000000}},
      {4{32'h40800000}});
    run("rnd", SPD_ROUND, 6'h0, 8'h04, '0, 128'h3fc0000040200000bfc000003f000000,
      128'h3f80000040000000c000000000000000);
    run("rsd", SPD_ROUND, 6'h3, 8'h0, {2{64'h1}}, 128'h4004000000000000,
      {64'h1, 64'h4000000000000000});
  endtask
  task automatic sc_sel;
    run("bw", SPD_IMM_BLEND, 6'h10, 8'ha5, {8{16'haaaa}}, {8{16'h5555}},
      128'h5555aaaa5555aaaaaaaa5555aaaa5555);
    run("bb", SPD_MASK_BLEND, 6'h0, 8'h0, {16{8'h11}}, {16{8'h22}}, {8{16'h2211}});
    run("umin", SPD_MIN_MAX, 6'h10, 8'h0, {8{16'h8000}}, {8{16'h1}}, {8{16'h1}});
    run("smax", SPD_MIN_MAX, 6'h23, 8'h0, {4{32'h80000000}}, {4{32'h1}}, {4{32'h1}});
    run("smin", SPD_MIN_MAX, 6'h01, 8'h0, {16{8'h7f}}, {16{8'h80}}, {16{8'h80}});
    run("pack", SPD_SATURATING_PACK, 6'h0, 8'h0, {32'h12345, 32'hffffffff, 32'habcd, 32'h0},
      {4{32'h80000000}}, 128'hffff0000abcd0000);
    issue(SPD_HORIZONTAL_MIN, 6'h0, 8'h0, '0, 128'h0006000400080005000300070003_0009);
    chk("hmin", 128'h10003, 128'(result[31:0]));
    for (int i = 0; i < 3; i += 2) begin
      run("sad", SPD_BLOCK_SAD, 6'h0, 8'(i), {16{8'h10}}, 128'h20202020_00000000_04030201,
        (i == 0) ? {8{16'h36}} : {8{16'h40}});
    end
  endtask
  task automatic sc_move;
    logic [127:0] s = 128'h00000004_00000003_00000002_00000001;
    run("sxbw", SPD_WIDEN, 6'h06, 8'h0, '0, {4{16'h807f}}, {4{32'hff80007f}});
    run("zxdq", SPD_WIDEN, 6'h2c, 8'h0, '0, 128'h8000000000000001, {64'h80000000, 64'h1});
    issue(SPD_SINGLE_EXTRACT, 6'h0, 8'h2, '0, s);
    chk("sext", 128'h3, 128'(gpr_out));
    issue(SPD_INT_EXTRACT, 6'h10, 8'd12, '0, s);
    chk("wext", 128'h3, 128'(gpr_out));
    run("bins", SPD_INT_INSERT, 6'h0, 8'h3, '0, '0, 128'hab000000);
    gpr_in = 64'h3f800000;
    run("sins", SPD_SINGLE_INSERT, 6'h2, 8'h18, {4{32'h11111111}}, '0,
      128'h00000000_11111111_3f800000_11111111);
    issue(SPD_PACKED_TEST, 6'h0, 8'h0, 128'hf0, 128'h0f);
    chk("flags", 128'h2, 128'({zero_flag, carry_flag}));
    issue(SPD_PACKED_TEST, 6'h0, 8'h0, 128'h0f, 128'hff);
    chk("flags", 128'h1, 128'({zero_flag, carry_flag}));
    run("qeq", SPD_QWORD_EQUAL, 6'h0, 8'h0, {64'h1, 64'h2}, {64'h1, 64'h3}, {{64{1'b1}}, 64'h0});
  endtask
  task automatic sc_stream;
    addr = 64'h1230;
    issue(SPD_STREAMING_LOAD, 6'h0, 8'h0, '0, '0);
    chk("miss", 128'h1, 128'({out_valid, mem_req}));
    issue(SPD_QWORD_EQUAL, 6'h0, 8'h0, '0, '0);
    wait_out();
    chk("line", {96'h48, 32'h3}, result);
    addr = 64'h1210;
    run("hit", SPD_STREAMING_LOAD, 6'h0, 8'h0, '0, '0, {96'h48, 32'h1});
    stream_flush = 1'b1;
    lat = 8'h00;
    @(posedge clk);
    #1;
    stream_flush = 1'b0;
    addr = 64'h1220;
    issue(SPD_STREAMING_LOAD, 6'h0, 8'h0, '0, '0);
    chk("reload", 128'h1, 128'(mem_req));
    wait_out();
    chk("line2", {96'h48, 32'h2}, result);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    sc_int();
    sc_fp();
    sc_sel();
    sc_move();
    sc_stream();
    summarize();
  end
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule

/* File: bench/spd_core_props.sv */
// Port assertions for the packed-vector datapath.
`timescale 1ns/1ps
module spd_core_props
  import spd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire spd_cmd_s cmd,
  input wire logic [127:0] dst,
  input wire logic [127:0] src,
  input wire logic [63:0] addr,
  input wire logic fill_valid,
  input wire logic out_valid,
  input wire logic [127:0] result,
  input wire logic zero_flag,
  input wire logic carry_flag,
  input wire logic busy,
  input wire logic mem_req,
  input wire logic [SPD_LINE_TAG_BITS-1:0] mem_line_addr
);
  logic [127:0] d_reg, s_reg;
  logic [SPD_LINE_TAG_BITS-1:0] t_reg;
  always_ff @(posedge clk) begin
    d_reg <= dst;
    s_reg <= src;
    t_reg <= addr[63:6];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_op(spd_op_e o); in_valid && !busy && cmd.op == o; endsequence
  sequence s_miss; s_op(SPD_STREAMING_LOAD) ##1 mem_req; endsequence
  property p_lmul; s_op(SPD_LOW_DWORD_MULTIPLY) |=> out_valid && result[31:0] ==
    d_reg[31:0] * s_reg[31:0] && result[127:96] == d_reg[127:96] * s_reg[127:96]; endproperty
  a_lmul: assert property (p_lmul) else $error("low multiply wrong");
  property p_wmul; s_op(SPD_WIDENING_MULTIPLY) |=>
    result[63:0] == 64'($signed(d_reg[31:0])) * 64'($signed(s_reg[31:0])); endproperty
  a_wmul: assert property (p_wmul) else $error("wide mul wrong");
  property p_zf; s_op(SPD_PACKED_TEST) |=> zero_flag == ((d_reg & s_reg) == 128'h0); endproperty
  a_zf: assert property (p_zf) else $error("zero flag wrong");
  property p_cf; s_op(SPD_PACKED_TEST) |=> carry_flag == ((~s_reg & d_reg) == 128'h0); endproperty
  a_cf: assert property (p_cf) else $error("carry flag wrong");
  property p_keep; !(in_valid && !busy && cmd.op == SPD_PACKED_TEST) |=>
    $stable({zero_flag, carry_flag}); endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
  property p_qeq; s_op(SPD_QWORD_EQUAL) |=> result == {{64{d_reg[127:64] == s_reg[127:64]}},
    {64{d_reg[63:0] == s_reg[63:0]}}}; endproperty
  a_qeq: assert property (p_qeq) else $error("qword compare wrong");
  property p_miss; s_miss |-> busy && !out_valid && mem_line_addr == t_reg; endproperty
  a_miss: assert property (p_miss) else $error("miss wrong");
  property p_fill; mem_req && fill_valid |=> !mem_req ##1 out_valid && !busy; endproperty
  a_fill: assert property (p_fill) else $error("fill wrong");
  property p_hit; s_op(SPD_STREAMING_LOAD) |=> out_valid ^ mem_req; endproperty
  a_hit: assert property (p_hit) else $error("load lost");
endmodule
bind spd_core spd_core_props u_props(.clk(clk), .sys_rst(sys_rst), .in_valid(in_valid),
  .cmd(cmd), .dst(dst), .src(src), .addr(addr), .fill_valid(fill_valid), .out_valid(out_valid),
  .result(result), .zero_flag(zero_flag), .carry_flag(carry_flag), .busy(busy),
  .mem_req(mem_req), .mem_line_addr(mem_line_addr));

/* File: bench/spd_mem_model.sv */
// Line memory model that answers streaming line requests after a set latency.
`timescale 1ns/1ps
module spd_mem_model
  import spd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mem_req,
  input wire logic [SPD_LINE_TAG_BITS-1:0] line_addr,
  input wire logic [7:0] lat,
  output logic fill_valid = 1'b0,
  output logic [SPD_LINE_BITS-1:0] fill_line = '0
);
  logic [7:0] cnt_reg = '0;
  // Idle line data flips every cycle so a stale sample never matches.
  always @(posedge clk) begin
    fill_valid <= 1'b0;
    fill_line <= ~fill_line;
    cnt_reg <= (mem_req && !fill_valid) ? cnt_reg + 8'h01 : 8'h00;
    if (!sys_rst && mem_req && !fill_valid && cnt_reg == lat) begin
      fill_valid <= 1'b1;
      for (int k = 0; k < 4; k++) fill_line[k*128 +: 128] <= {96'(line_addr), 32'(k)};
    end
  end
endmodule

/* File: design/spd_core.sv */
// Packed-vector datapath with one-cycle results and streaming loads.
// Behaviour
// - Negate dst elements whose src element is negative.
// - Align returns a 128 or 64 bit slice of dst:src.
// - Low multiply keeps low 32 product bits.
// - Widening multiply keeps full 64-bit signed products.
// - Dot product sums selected products, broadcasts the sum.
// - Streaming misses fetch the whole 64-byte line into a buffer.
// - Later loads to a buffered line come from the buffer.
// - Immediate blends copy selected source elements.
// - Mask blends copy elements whose mask sign bit is set.
// - Min and max compare signed or unsigned elements.
// - Round to integral floats; scalar forms touch only element zero.
// - Single extract returns the chosen element.
// - Single insert places a value, zeroes masked elements.
// - Integer insert and extract move one element.
// - Sign widening replicates the sign bit.
// - Zero widening fills upper bits with zeros.
// - Block SAD gives eight word sums over 4-byte groups.
// - Horizontal minimum packs least word and its index.
// - Zero flag set when dst AND src is zero.
// - Carry flag set when inverted src AND dst is zero.
// - Qword equality gives a per-lane all-ones or zero mask.
// - Pack narrows signed dwords to words, unsigned saturation.
`timescale 1ns/1ps
module spd_core
  import spd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  input wire spd_cmd_s cmd,
  input wire logic [127:0] dst,
  input wire logic [127:0] src,
  input wire logic [127:0] mask,
  input wire logic [7:0] imm,
  input wire logic [63:0] gpr_in,
  input wire logic [63:0] addr,
  input wire logic [1:0] round_ctl,
  input wire logic stream_flush,
  input wire logic fill_valid,
  input wire logic [SPD_LINE_BITS-1:0] fill_line,
  output logic out_valid,
  output logic [127:0] result,
  output logic [63:0] gpr_out,
  output logic zero_flag,
  output logic carry_flag,
  output logic busy,
  output logic mem_req,
  output logic [SPD_LINE_TAG_BITS-1:0] mem_line_addr
);

  logic valid_reg, valid_next, busy_reg, busy_next, zf_reg, zf_next, cf_reg, cf_next;
  logic [127:0] result_reg, result_next, res;
  logic [63:0] gpr_reg, gpr_next, gpr, la, lb, sum, p0, p1, p2, p3;
  logic [255:0] cat;
  logic signed [63:0] prod;
  logic [15:0] acc, mv;
  logic [2:0] mi;
  logic [1:0] md;
  logic [31:0] fs;
  logic accept, lookup, hit, done, less;
  logic [127:0] hit_data, done_data;
  int w, dw, idx;

  function automatic logic [63:0] lane_mask(input int w);
    lane_mask = (w >= 64) ? '1 : ((64'h1 << w) - 64'h1);
  endfunction

  function automatic logic [63:0] lane_get(input logic [127:0] v, input int w, input int i);
    lane_get = 64'(v >> (i * w)) & lane_mask(w);
  endfunction

  function automatic logic [127:0] lane_put(input logic [127:0] v, input int w, input int i,
    input logic [63:0] x);
    lane_put = (v & ~({64'h0, lane_mask(w)} << (i * w)))
             | ({64'h0, x & lane_mask(w)} << (i * w));
  endfunction

  function automatic logic [63:0] sext(input logic [63:0] x, input int w);
    sext = x[w-1] ? (x | ~lane_mask(w)) : x;
  endfunction

  function automatic logic [63:0] s2d(input logic [31:0] a);
    if (a[30:23] == 8'h00) s2d = {a[31], 63'h0};
    else if (a[30:23] == 8'hff) s2d = {a[31], 11'h7ff, a[22:0], 29'h0};
    else s2d = {a[31], {3'h0, a[30:23]} + SPD_SGL_TO_DBL_BIAS, a[22:0], 29'h0};
  endfunction

  function automatic logic [31:0] d2s(input logic [63:0] a);
    logic signed [12:0] e;
    e = $signed({2'b00, a[62:52]}) - $signed({2'b00, SPD_SGL_TO_DBL_BIAS});
    if (a[62:52] == 11'h7ff) d2s = {a[63], 8'hff, a[51:29]};
    else if (a[62:52] == 11'h000 || e <= 13'sh0000) d2s = {a[63], 31'h0};
    else if (e >= 13'sh00ff) d2s = {a[63], 8'hff, 23'h0};
    else d2s = {a[63], e[7:0], a[51:29]};
  endfunction

  // Products truncate; zero or subnormal operands give zero.
  function automatic logic [63:0] fp_mul(input logic [63:0] a, input logic [63:0] b);
    logic signed [12:0] e;
    logic [105:0] m;
    e = $signed({2'b00, a[62:52]}) + $signed({2'b00, b[62:52]}) - SPD_DBL_BIAS;
    m = {53'h1, a[51:0]} * {53'h1, b[51:0]};
    if (m[105]) begin
      e = e + 13'sh0001;
      m = m >> 1;
    end
    if (a[62:52] == 11'h000 || b[62:52] == 11'h000 || e <= 13'sh0000) fp_mul = {a[63] ^ b[63], 63'h0};
    else if (e >= SPD_DBL_EMAX) fp_mul = {a[63] ^ b[63], 11'h7ff, 52'h0};
    else fp_mul = {a[63] ^ b[63], e[10:0], m[103:52]};
  endfunction

  function automatic logic [63:0] fp_add(input logic [63:0] a, input logic [63:0] b);
    logic [63:0] x, y, ma, mb;
    logic [10:0] d;
    logic signed [12:0] e;
    if (a[62:0] >= b[62:0]) begin
      x = a;
      y = b;
    end else begin
      x = b;
      y = a;
    end
    d = x[62:52] - y[62:52];
    ma = {2'b01, x[51:0], 10'h000};
    mb = (y[62:52] == 11'h000 || d > 11'h03f) ? 64'h0 : ({2'b01, y[51:0], 10'h000} >> d);
    ma = (x[63] == y[63]) ? ma + mb : ma - mb;
    e = $signed({2'b00, x[62:52]});
    if (ma[63]) begin
      ma = ma >> 1;
      e = e + 13'sh0001;
    end
    for (int i = 0; i < 62; i++) begin
      if (!ma[62] && ma != 64'h0) begin
        ma = ma << 1;
        e = e - 13'sh0001;
      end
    end
    if (x[62:52] == 11'h000 || ma == 64'h0 || e <= 13'sh0000) fp_add = {x[63] & y[63], 63'h0};
    else if (e >= SPD_DBL_EMAX) fp_add = {x[63], 11'h7ff, 52'h0};
    else fp_add = {x[63], e[10:0], ma[61:10]};
  endfunction

  function automatic logic [63:0] fp_round(input logic [63:0] a, input logic [1:0] md);
    logic signed [12:0] e;
    logic [53:0] mant, ip, rem, half, v;
    logic inc, nz;
    int f;
    e = $signed({2'b00, a[62:52]}) - SPD_DBL_BIAS;
    nz = a[62:0] != 63'h0;
    inc = 1'b0;
    if (e >= SPD_DBL_FRAC) return a;
    if (e < 13'sh0000) begin
      case (md)
        SPD_RND_NEAREST: inc = (e == -13'sh0001) && (a[51:0] != 52'h0);
        SPD_RND_DOWN: inc = a[63] && nz;
        SPD_RND_UP: inc = !a[63] && nz;
        default: inc = 1'b0;
      endcase
      return inc ? {a[63], SPD_DBL_BIAS[10:0], 52'h0} : {a[63], 63'h0};
    end
    f = int'(SPD_DBL_FRAC) - int'(e);
    mant = {2'b01, a[51:0]};
    ip = mant >> f;
    rem = mant & ((54'h1 << f) - 54'h1);
    half = 54'h1 << (f - 1);
    case (md)
      SPD_RND_NEAREST: inc = (rem > half) || (rem == half && ip[0]);
      SPD_RND_DOWN: inc = a[63] && rem != 54'h0;
      SPD_RND_UP: inc = !a[63] && rem != 54'h0;
      default: inc = 1'b0;
    endcase
    v = (ip + {53'h0, inc}) << f;
    if (v[53]) return {a[63], a[62:52] + 11'h001, v[52:1]};
    return {a[63], a[62:52], v[51:0]};
  endfunction

  spd_stream_buf u_stream_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .lookup(lookup),
    .addr(addr),
    .invalidate(stream_flush),
    .fill_valid(fill_valid),
    .fill_line(fill_line),
    .hit(hit),
    .hit_data(hit_data),
    .mem_req(mem_req),
    .mem_line_addr(mem_line_addr),
    .done(done),
    .done_data(done_data)
  );

  assign accept = in_valid && !busy_reg;
  assign lookup = accept && cmd.op == SPD_STREAMING_LOAD;

  always_comb begin
    res = dst;
    gpr = 64'h0;
    zf_next = zf_reg;
    cf_next = cf_reg;
    w = 8 << cmd.esize;
    dw = 8 << cmd.dsize;
    idx = int'(imm) & ((128 / w) - 1);
    la = 64'h0;
    lb = 64'h0;
    sum = 64'h0;
    p0 = 64'h0;
    p1 = 64'h0;
    p2 = 64'h0;
    p3 = 64'h0;
    cat = {dst, src};
    prod = 64'sh0;
    acc = 16'h0;
    mv = 16'h0;
    mi = 3'h0;
    md = imm[SPD_IMM_MODE_SEL] ? round_ctl : imm[1:0];
    fs = 32'h0;
    less = 1'b0;
    case (cmd.op)
      SPD_APPLY_SIGN: begin
        for (int i = 0; i < 16; i++) begin
          if (i < 128 / w) begin
            la = sext(lane_get(dst, w, i), w);
            lb = sext(lane_get(src, w, i), w);
            if (lb[63]) res = lane_put(res, w, i, 64'h0 - la);
            else if (lb == 64'h0) res = lane_put(res, w, i, 64'h0);
          end
        end
      end
      SPD_BYTE_ALIGN_CONCAT: begin
        if (cmd.flag_a) res = {64'h0, 64'({dst[63:0], src[63:0]} >> (int'(imm) * 8))};
        else res = 128'(cat >> (int'(imm) * 8));
      end
      SPD_LOW_DWORD_MULTIPLY: begin
        for (int i = 0; i < 4; i++) begin
          prod = $signed(dst[i*32 +: 32]) * $signed(src[i*32 +: 32]);
          res[i*32 +: 32] = prod[31:0];
        end
      end
      SPD_WIDENING_MULTIPLY: begin
        for (int i = 0; i < 2; i++) begin
          prod = $signed(dst[i*64 +: 32]) * $signed(src[i*64 +: 32]);
          res[i*64 +: 64] = prod;
        end
      end
      SPD_DOT_PRODUCT: begin
        if (cmd.flag_a) begin
          p0 = imm[SPD_IMM_SEL_LO] ? fp_mul(dst[63:0], src[63:0]) : 64'h0;
          p1 = imm[SPD_IMM_SEL_LO+1] ? fp_mul(dst[127:64], src[127:64]) : 64'h0;
          sum = fp_add(p0, p1);
          for (int i = 0; i < 2; i++) res[i*64 +: 64] = imm[i] ? sum : 64'h0;
        end else begin
          p0 = imm[SPD_IMM_SEL_LO] ? fp_mul(s2d(dst[31:0]), s2d(src[31:0])) : 64'h0;
          p1 = imm[SPD_IMM_SEL_LO+1] ? fp_mul(s2d(dst[63:32]), s2d(src[63:32])) : 64'h0;
          p2 = imm[SPD_IMM_SEL_LO+2] ? fp_mul(s2d(dst[95:64]), s2d(src[95:64])) : 64'h0;
          p3 = imm[SPD_IMM_SEL_LO+3] ? fp_mul(s2d(dst[127:96]), s2d(src[127:96])) : 64'h0;
          fs = d2s(fp_add(fp_add(p0, p1), fp_add(p2, p3)));
          for (int i = 0; i < 4; i++) res[i*32 +: 32] = imm[i] ? fs : 32'h0;
        end
      end
      SPD_STREAMING_LOAD: res = hit_data;
      SPD_IMM_BLEND: begin
        for (int i = 0; i < 8; i++) begin
          if (i < 128 / w && imm[i]) res = lane_put(res, w, i, lane_get(src, w, i));
        end
      end
      SPD_MASK_BLEND: begin
        for (int i = 0; i < 16; i++) begin
          if (i < 128 / w && mask[i*w + w - 1]) res = lane_put(res, w, i, lane_get(src, w, i));
        end
      end
      SPD_MIN_MAX: begin
        for (int i = 0; i < 16; i++) begin
          if (i < 128 / w) begin
            la = cmd.flag_b ? sext(lane_get(dst, w, i), w) : lane_get(dst, w, i);
            lb = cmd.flag_b ? sext(lane_get(src, w, i), w) : lane_get(src, w, i);
            less = cmd.flag_b ? ($signed(lb) < $signed(la)) : (lb < la);
            if (less != cmd.flag_a && la != lb) res = lane_put(res, w, i, lb);
          end
        end
      end
      SPD_ROUND: begin
        if (!cmd.flag_b) res = src;
        if (cmd.flag_a) begin
          for (int i = 0; i < 2; i++) begin
            if (i == 0 || !cmd.flag_b) res[i*64 +: 64] = fp_round(src[i*64 +: 64], md);
          end
        end else begin
          for (int i = 0; i < 4; i++) begin
            if (i == 0 || !cmd.flag_b) res[i*32 +: 32] = d2s(fp_round(s2d(src[i*32 +: 32]), md));
          end
        end
      end
      SPD_SINGLE_EXTRACT: gpr = {32'h0, src[imm[1:0]*32 +: 32]};
      SPD_SINGLE_INSERT: begin
        fs = cmd.flag_a ? gpr_in[31:0] : src[imm[SPD_IMM_INS_SRC +: 2]*32 +: 32];
        res[imm[SPD_IMM_INS_DST +: 2]*32 +: 32] = fs;
        for (int i = 0; i < 4; i++) if (imm[i]) res[i*32 +: 32] = 32'h0;
      end
      SPD_INT_INSERT: res = lane_put(dst, w, idx, gpr_in);
      SPD_INT_EXTRACT: gpr = lane_get(src, w, idx);
      SPD_WIDEN: begin
        res = 128'h0;
        for (int i = 0; i < 8; i++) begin
          if (i < 128 / dw) begin
            la = lane_get(src, w, i);
            res = lane_put(res, dw, i, cmd.flag_a ? sext(la, w) : la);
          end
        end
      end
      SPD_BLOCK_SAD: begin
        for (int i = 0; i < 8; i++) begin
          acc = 16'h0;
          for (int k = 0; k < 4; k++) begin
            la = {56'h0, dst[(int'(imm[2]) * 4 + i + k) * 8 +: 8]};
            lb = {56'h0, src[(int'(imm[1:0]) * 4 + k) * 8 +: 8]};
            acc = acc + 16'((la > lb) ? la - lb : lb - la);
          end
          res[i*16 +: 16] = acc;
        end
      end
      SPD_HORIZONTAL_MIN: begin
        mv = src[15:0];
        for (int i = 1; i < 8; i++) begin
          if (src[i*16 +: 16] < mv) begin
            mv = src[i*16 +: 16];
            mi = 3'(i);
          end
        end
        res = {109'h0, mi, mv};
      end
      SPD_PACKED_TEST: begin
        if (accept) zf_next = (dst & src) == 128'h0;
        if (accept) cf_next = (~src & dst) == 128'h0;
      end
      SPD_QWORD_EQUAL: begin
        res = {{64{dst[127:64] == src[127:64]}}, {64{dst[63:0] == src[63:0]}}};
      end
      SPD_SATURATING_PACK: begin
        cat = {src, dst};
        for (int i = 0; i < 8; i++) begin
          if (cat[i*32 + 31]) res[i*16 +: 16] = 16'h0000;
          else if (cat[i*32 + 16 +: 15] != 15'h0) res[i*16 +: 16] = 16'hffff;
          else res[i*16 +: 16] = cat[i*32 +: 16];
        end
      end
      default: res = dst;
    endcase
  end

  always_comb begin
    valid_next = done || (accept && !(lookup && !hit));
    busy_next = busy_reg ? !done : (lookup && !hit);
    result_next = result_reg;
    gpr_next = gpr_reg;
    if (done) result_next = done_data;
    else if (valid_next) begin
      result_next = res;
      gpr_next = gpr;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      valid_reg <= 1'b0;
      busy_reg <= 1'b0;
      zf_reg <= 1'b0;
      cf_reg <= 1'b0;
      result_reg <= '0;
      gpr_reg <= '0;
    end else begin
      valid_reg <= valid_next;
      busy_reg <= busy_next;
      zf_reg <= zf_next;
      cf_reg <= cf_next;
      result_reg <= result_next;
      gpr_reg <= gpr_next;
    end
  end

  assign out_valid = valid_reg;
  assign result = result_reg;
  assign gpr_out = gpr_reg;
  assign zero_flag = zf_reg;
  assign carry_flag = cf_reg;
  assign busy = busy_reg;

endmodule

/* File: design/spd_pkg.sv */
// Shared operation codes, command layout and constants of the packed-vector datapath.
package spd_pkg;

  typedef enum logic [4:0] {
    SPD_NOP                = 5'h00,
    SPD_APPLY_SIGN         = 5'h01,
    SPD_BYTE_ALIGN_CONCAT  = 5'h02,
    SPD_LOW_DWORD_MULTIPLY = 5'h03,
    SPD_WIDENING_MULTIPLY  = 5'h04,
    SPD_DOT_PRODUCT        = 5'h05,
    SPD_STREAMING_LOAD     = 5'h06,
    SPD_IMM_BLEND          = 5'h07,
    SPD_MASK_BLEND         = 5'h08,
    SPD_MIN_MAX            = 5'h09,
    SPD_ROUND              = 5'h0a,
    SPD_SINGLE_EXTRACT     = 5'h0b,
    SPD_SINGLE_INSERT      = 5'h0c,
    SPD_INT_INSERT         = 5'h0d,
    SPD_INT_EXTRACT        = 5'h0e,
    SPD_WIDEN              = 5'h0f,
    SPD_BLOCK_SAD          = 5'h10,
    SPD_HORIZONTAL_MIN     = 5'h11,
    SPD_PACKED_TEST        = 5'h12,
    SPD_QWORD_EQUAL        = 5'h13,
    SPD_SATURATING_PACK    = 5'h14
  } spd_op_e;

  // Element size codes used by esize and dsize.
  localparam logic [1:0] SPD_SIZE_BYTE = 2'h0;
  localparam logic [1:0] SPD_SIZE_WORD = 2'h1;
  localparam logic [1:0] SPD_SIZE_DWORD = 2'h2;
  localparam logic [1:0] SPD_SIZE_QWORD = 2'h3;

  localparam logic [1:0] SPD_RND_NEAREST = 2'h0;
  localparam logic [1:0] SPD_RND_DOWN = 2'h1;
  localparam logic [1:0] SPD_RND_UP = 2'h2;
  localparam logic [1:0] SPD_RND_TRUNC = 2'h3;

  localparam int SPD_IMM_MODE_SEL = 2;
  localparam int SPD_IMM_SEL_LO = 4;
  localparam int SPD_IMM_INS_DST = 4;
  localparam int SPD_IMM_INS_SRC = 6;

  localparam int SPD_LINE_BITS = 512;
  localparam int SPD_ITEM_BITS = 128;
  localparam int SPD_LINE_TAG_BITS = 58;
  localparam int SPD_SLB_ENTRIES = 2;

  localparam logic signed [12:0] SPD_DBL_BIAS = 13'sh03ff;
  localparam logic signed [12:0] SPD_DBL_EMAX = 13'sh07ff;
  localparam logic signed [12:0] SPD_DBL_FRAC = 13'sh0034;
  localparam logic [10:0] SPD_SGL_TO_DBL_BIAS = 11'h380;

  typedef struct packed {
    spd_op_e op;
    logic [1:0] esize;
    logic [1:0] dsize;
    logic flag_a;
    logic flag_b;
  } spd_cmd_s;

endpackage

/* File: design/spd_stream_buf.sv */
// Streaming load buffers for whole aligned lines.
`timescale 1ns/1ps
module spd_stream_buf
  import spd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic lookup,
  input wire logic [63:0] addr,
  input wire logic invalidate,
  input wire logic fill_valid,
  input wire logic [SPD_LINE_BITS-1:0] fill_line,
  output logic hit,
  output logic [SPD_ITEM_BITS-1:0] hit_data,
  output logic mem_req,
  output logic [SPD_LINE_TAG_BITS-1:0] mem_line_addr,
  output logic done,
  output logic [SPD_ITEM_BITS-1:0] done_data
);

  typedef enum logic {SPD_SLB_IDLE = 1'b0, SPD_SLB_FILL = 1'b1} spd_slb_state_e;

  spd_slb_state_e state_reg, state_next;
  logic [SPD_LINE_TAG_BITS-1:0] tag_reg [SPD_SLB_ENTRIES], tag_next [SPD_SLB_ENTRIES];
  logic [SPD_LINE_BITS-1:0] line_reg [SPD_SLB_ENTRIES], line_next [SPD_SLB_ENTRIES];
  logic [SPD_SLB_ENTRIES-1:0] vld_reg, vld_next;
  logic victim_reg, victim_next;
  logic [63:0] addr_reg, addr_next;
  logic req_reg, req_next;
  logic done_reg, done_next;
  logic [SPD_ITEM_BITS-1:0] data_reg, data_next;

  function automatic logic [SPD_ITEM_BITS-1:0] item_of(input logic [SPD_LINE_BITS-1:0] line,
    input logic [1:0] sel);
    item_of = line[sel*SPD_ITEM_BITS +: SPD_ITEM_BITS];
  endfunction

  always_comb begin
    hit = 1'b0;
    hit_data = '0;
    for (int i = 0; i < SPD_SLB_ENTRIES; i++) begin
      if (vld_reg[i] && tag_reg[i] == addr[63:6]) begin
        hit = lookup;
        hit_data = item_of(line_reg[i], addr[5:4]);
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    tag_next = tag_reg;
    line_next = line_reg;
    vld_next = invalidate ? '0 : vld_reg;
    victim_next = victim_reg;
    addr_next = addr_reg;
    req_next = req_reg;
    done_next = 1'b0;
    data_next = data_reg;
    case (state_reg)
      SPD_SLB_IDLE: begin
        if (lookup && !hit) begin
          addr_next = addr;
          req_next = 1'b1;
          state_next = SPD_SLB_FILL;
        end
      end
      SPD_SLB_FILL: begin
        if (fill_valid) begin
          tag_next[victim_reg] = addr_reg[63:6];
          line_next[victim_reg] = fill_line;
          vld_next[victim_reg] = 1'b1;
          victim_next = ~victim_reg;
          req_next = 1'b0;
          done_next = 1'b1;
          data_next = item_of(fill_line, addr_reg[5:4]);
          state_next = SPD_SLB_IDLE;
        end
      end
      default: state_next = SPD_SLB_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= SPD_SLB_IDLE;
      for (int i = 0; i < SPD_SLB_ENTRIES; i++) begin
        tag_reg[i] <= '0;
        line_reg[i] <= '0;
      end
      vld_reg <= '0;
      victim_reg <= 1'b0;
      addr_reg <= '0;
      req_reg <= 1'b0;
      done_reg <= 1'b0;
      data_reg <= '0;
    end else begin
      state_reg <= state_next;
      tag_reg <= tag_next;
      line_reg <= line_next;
      vld_reg <= vld_next;
      victim_reg <= victim_next;
      addr_reg <= addr_next;
      req_reg <= req_next;
      done_reg <= done_next;
      data_reg <= data_next;
    end
  end

  assign mem_req = req_reg;
  assign mem_line_addr = addr_reg[63:6];
  assign done = done_reg;
  assign done_data = data_reg;

endmodule
